// [hw/qdac_top.sv]
// Function
// R1 - four 10-bit converter channels, all sharing one reference input
// R2 - a 16-bit input shift register carries channel, mode, power-down and code
// R3 - two mode bits pick update of one channel or all four together
// R4 - outputs sit at zero after reset until the first complete write
// R5 - power-down mode chosen by the word, with three termination choices; the code passes the 2-bit chan field to termination_o, so four values
// R6 - data bits sampled on falling serial clock edges after frame select falls
// R7 - frame select low enables the shift register; one bit per falling edge
// R8 - the 16th falling edge completes the word and it is applied
// R9 - frame select rising before the 16th edge discards the partial word
// R10 - host keeps the serial clock at or below 40 MHz
// R11 - host sends msb first, sixteen edges per frame, then raises frame select; the testbench host also sends frames of 10, 15 and up to 19 edges
// R12 - edges with frame select high ignored; each frame restarts the bit count
`timescale 1ns/1ps
module qdac_top #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_b_i,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0]          s_axi_awaddr_i,
  input  wire logic                       s_axi_awvalid_i,
  output logic                            s_axi_awready_o,
  input  wire logic [31:0]                s_axi_wdata_i,
  input  wire logic [3:0]                 s_axi_wstrb_i,
  input  wire logic                       s_axi_wvalid_i,
  output logic                            s_axi_wready_o,
  output logic [1:0]                      s_axi_bresp_o,
  output logic                            s_axi_bvalid_o,
  input  wire logic                       s_axi_bready_i,
  input  wire logic [ADDR_W-1:0]          s_axi_araddr_i,
  input  wire logic                       s_axi_arvalid_i,
  output logic                            s_axi_arready_o,
  output logic [31:0]                     s_axi_rdata_o,
  output logic [1:0]                      s_axi_rresp_o,
  output logic                            s_axi_rvalid_o,
  input  wire logic                       s_axi_rready_i,
  // serial link, own clock domain
  input  wire logic                       sclk_i,
  input  wire logic                       frame_sel_b_i,
  input  wire logic                       sdata_i,
  // converter side
  output logic [qdac_pkg::CODE_W-1:0]     channel_a_output_o,
  output logic [qdac_pkg::CODE_W-1:0]     channel_b_output_o,
  output logic [qdac_pkg::CODE_W-1:0]     channel_c_output_o,
  output logic [qdac_pkg::CODE_W-1:0]     channel_d_output_o,
  output logic                            power_down_o,
  output logic [1:0]                      termination_o
);

  // ----------------------------------------
  // link domain: shift register
  // ----------------------------------------
  logic                            link_rst_b;
  logic [4:0]                      bit_cnt;
  logic [4:0]                      next_bit_cnt;
  logic [qdac_pkg::WORD_W-1:0]     shift;
  logic [qdac_pkg::WORD_W-1:0]     next_shift;
  logic [qdac_pkg::WORD_W-1:0]     word_hold;
  logic [qdac_pkg::WORD_W-1:0]     next_word_hold;
  logic                            word_tgl;
  logic                            next_word_tgl;

  // frame select high clears the count at once, so a stopped clock cannot
  // leave a partial frame half counted
  assign link_rst_b = rst_b_i & ~frame_sel_b_i; // R9 R12

  // next shift state; edges past the 16th are ignored
  always_comb
  begin
    next_shift     = shift;
    next_bit_cnt   = bit_cnt;
    next_word_hold = word_hold;
    next_word_tgl  = word_tgl;
    if (bit_cnt != qdac_pkg::FRAME_BITS)
    begin
      next_shift   = {shift[qdac_pkg::WORD_W-2:0], sdata_i}; // R6 R7
      next_bit_cnt = bit_cnt + 5'h01;
      if (bit_cnt == qdac_pkg::FRAME_BITS - 5'h01)
      begin
        next_word_hold = {shift[qdac_pkg::WORD_W-2:0], sdata_i}; // R8
        next_word_tgl  = ~word_tgl; // R8
      end
    end
  end

  // frame state, cleared whenever frame select is high
  always_ff @(negedge sclk_i or negedge link_rst_b)
  begin
    if (!link_rst_b)
    begin
      bit_cnt <= 5'h00; // R12
      shift   <= '0;
    end
    else
    begin
      bit_cnt <= next_bit_cnt;
      shift   <= next_shift;
    end
  end

  // completed word survives frame select; held until the next full frame
  always_ff @(negedge sclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      word_hold <= '0;
      word_tgl  <= 1'b0;
    end
    else
    begin
      word_hold <= next_word_hold;
      word_tgl  <= next_word_tgl;
    end
  end

  // ----------------------------------------
  // crossing into the system domain
  // ----------------------------------------
  logic [2:0] tgl_sync;
  logic [2:0] next_tgl_sync;
  logic       word_evt;

  // word_hold is stable long before the toggle is seen, so no bus sync needed
  always_comb
  begin
    next_tgl_sync = {tgl_sync[1:0], word_tgl};
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tgl_sync <= 3'h0;
    end
    else
    begin
      tgl_sync <= next_tgl_sync;
    end
  end

  assign word_evt = tgl_sync[2] ^ tgl_sync[1];

  // ----------------------------------------
  // converter registers
  // ----------------------------------------
  qdac_pkg::qdac_word_t        rx_word;
  logic [qdac_pkg::CODE_W-1:0] in_reg    [qdac_pkg::NUM_CH];
  logic [qdac_pkg::CODE_W-1:0] next_in   [qdac_pkg::NUM_CH];
  logic [qdac_pkg::CODE_W-1:0] out_reg   [qdac_pkg::NUM_CH];
  logic [qdac_pkg::CODE_W-1:0] next_out  [qdac_pkg::NUM_CH];
  logic                        pd;
  logic                        next_pd;
  logic [1:0]                  term;
  logic [1:0]                  next_term;
  logic                        loaded;
  logic                        next_loaded;
  logic [15:0]                 frame_cnt;
  logic [15:0]                 next_frame_cnt;
  logic                        ctrl_en;
  logic                        next_ctrl_en;

  assign rx_word = qdac_pkg::qdac_word_t'(word_hold); // R2

  // apply a completed word; a disabled block drops it
  always_comb
  begin
    next_in        = in_reg;
    next_out       = out_reg;
    next_pd        = pd;
    next_term      = term;
    next_loaded    = loaded;
    next_frame_cnt = frame_cnt;
    if (word_evt && ctrl_en)
    begin
      next_loaded    = 1'b1;
      next_frame_cnt = frame_cnt + 16'h0001;
      case (rx_word.mode) // R3
        qdac_pkg::QDAC_MODE_LOAD:
        begin
          next_in[rx_word.chan] = rx_word.code;
        end
        qdac_pkg::QDAC_MODE_UPD_ONE:
        begin
          next_in[rx_word.chan]  = rx_word.code;
          next_out[rx_word.chan] = rx_word.code; // R3
          next_pd                = 1'b0;
        end
        qdac_pkg::QDAC_MODE_UPD_ALL:
        begin
          next_in[rx_word.chan] = rx_word.code;
          next_out              = next_in; // R3
          next_pd               = 1'b0;
        end
        default:
        begin
          // outputs parked at zero; the chan field picks the termination
          next_pd   = 1'b1; // R5
          next_term = rx_word.chan; // R5
          for (int i = 0; i < qdac_pkg::NUM_CH; i++)
          begin
            next_out[i] = '0;
          end
        end
      endcase
    end
  end

  // zero after reset, held there until a word arrives
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      for (int i = 0; i < qdac_pkg::NUM_CH; i++)
      begin
        in_reg[i]  <= '0;
        out_reg[i] <= '0; // R4
      end
      pd        <= 1'b0;
      term      <= 2'h0;
      loaded    <= 1'b0;
      frame_cnt <= 16'h0000;
    end
    else
    begin
      in_reg    <= next_in;
      out_reg   <= next_out;
      pd        <= next_pd;
      term      <= next_term;
      loaded    <= next_loaded;
      frame_cnt <= next_frame_cnt;
    end
  end

  // one reference serves all four; codes go out as plain words
  assign channel_a_output_o = out_reg[0]; // R1
  assign channel_b_output_o = out_reg[1];
  assign channel_c_output_o = out_reg[2];
  assign channel_d_output_o = out_reg[3];
  assign power_down_o       = pd;
  assign termination_o      = term;

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  logic              aw_full;
  logic              next_aw_full;
  logic [ADDR_W-1:0] aw_addr;
  logic [ADDR_W-1:0] next_aw_addr;
  logic              w_full;
  logic              next_w_full;
  logic [31:0]       w_data;
  logic [31:0]       next_w_data;
  logic [3:0]        w_strb;
  logic [3:0]        next_w_strb;
  logic              bvalid;
  logic              next_bvalid;
  logic [1:0]        bresp;
  logic [1:0]        next_bresp;
  logic              rvalid;
  logic              next_rvalid;
  logic [31:0]       rdata;
  logic [31:0]       next_rdata;
  logic [1:0]        rresp;
  logic [1:0]        next_rresp;

  // word offsets that answer OKAY
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] o;
    o = 8'(a);
    return (o == qdac_pkg::OFS_CTRL) || (o == qdac_pkg::OFS_STATUS) ||
           (o == qdac_pkg::OFS_CODE_AB) || (o == qdac_pkg::OFS_CODE_CD);
  endfunction

  assign s_axi_awready_o = ~aw_full;
  assign s_axi_wready_o  = ~w_full;
  assign s_axi_arready_o = ~rvalid;
  assign s_axi_bvalid_o  = bvalid;
  assign s_axi_bresp_o   = bresp;
  assign s_axi_rvalid_o  = rvalid;
  assign s_axi_rdata_o   = rdata;
  assign s_axi_rresp_o   = rresp;

  // write: address and data taken in either order, then one response
  always_comb
  begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full  = w_full;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_ctrl_en = ctrl_en;
    if (s_axi_awvalid_i && !aw_full)
    begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !w_full)
    begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata_i;
      next_w_strb = s_axi_wstrb_i;
    end
    if (bvalid && s_axi_bready_i)
    begin
      next_bvalid = 1'b0;
    end
    // status and code words are read-only; writes to them are dropped
    if (aw_full && w_full && !bvalid)
    begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = is_mapped(aw_addr) ? qdac_pkg::RESP_OKAY : qdac_pkg::RESP_SLVERR;
      if ((8'(aw_addr) == qdac_pkg::OFS_CTRL) && w_strb[0])
      begin
        next_ctrl_en = w_data[qdac_pkg::CTRL_EN_POS];
      end
    end
  end

  // read: one cycle from address to data
  always_comb
  begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (rvalid && s_axi_rready_i)
    begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && !rvalid)
    begin
      next_rvalid = 1'b1;
      next_rresp  = is_mapped(s_axi_araddr_i) ? qdac_pkg::RESP_OKAY : qdac_pkg::RESP_SLVERR;
      next_rdata  = 32'h0000_0000;
      if (8'(s_axi_araddr_i) == qdac_pkg::OFS_CTRL)
      begin
        next_rdata[qdac_pkg::CTRL_EN_POS] = ctrl_en;
      end
      else if (8'(s_axi_araddr_i) == qdac_pkg::OFS_STATUS)
      begin
        next_rdata[qdac_pkg::ST_PD_POS]                 = pd;
        next_rdata[qdac_pkg::ST_TERM_POS +: 2]          = term;
        next_rdata[qdac_pkg::ST_LOAD_POS]               = loaded;
        next_rdata[qdac_pkg::ST_CNT_POS +: 16]          = frame_cnt;
      end
      else if (8'(s_axi_araddr_i) == qdac_pkg::OFS_CODE_AB)
      begin
        next_rdata[qdac_pkg::CODE_W-1:0]                  = out_reg[0];
        next_rdata[qdac_pkg::CODE_HI_POS +: qdac_pkg::CODE_W] = out_reg[1];
      end
      else if (8'(s_axi_araddr_i) == qdac_pkg::OFS_CODE_CD)
      begin
        next_rdata[qdac_pkg::CODE_W-1:0]                  = out_reg[2];
        next_rdata[qdac_pkg::CODE_HI_POS +: qdac_pkg::CODE_W] = out_reg[3];
      end
    end
  end

  // bus state
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      aw_full <= 1'b0;
      aw_addr <= '0;
      w_full  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= 2'h0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= 2'h0;
      ctrl_en <= qdac_pkg::CTRL_EN_RST;
    end
    else
    begin
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full  <= next_w_full;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
      ctrl_en <= next_ctrl_en;
    end
  end

endmodule

// [hw/qdac_pkg.sv]
package qdac_pkg;

  // ----------------------------------------
  // converter and link sizes
  // ----------------------------------------
  localparam int unsigned CODE_W  = 10;
  localparam int unsigned WORD_W  = 16;
  localparam int unsigned NUM_CH  = 4;
  localparam logic [4:0]  FRAME_BITS = 5'h10;

  // ----------------------------------------
  // register map, byte offsets
  // ----------------------------------------
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_STATUS  = 8'h04;
  localparam logic [7:0]  OFS_CODE_AB = 8'h08;
  localparam logic [7:0]  OFS_CODE_CD = 8'h0c;

  // field positions and reset values
  localparam int unsigned CTRL_EN_POS  = 0;
  localparam logic        CTRL_EN_RST  = 1'b1;
  localparam int unsigned ST_PD_POS    = 0;
  localparam int unsigned ST_TERM_POS  = 1;
  localparam int unsigned ST_LOAD_POS  = 3;
  localparam int unsigned ST_CNT_POS   = 16;
  localparam int unsigned CODE_HI_POS  = 16;

  // bus answers
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // received word layout
  // ----------------------------------------
  typedef enum logic [1:0] {
    QDAC_MODE_LOAD,
    QDAC_MODE_UPD_ONE,
    QDAC_MODE_UPD_ALL,
    QDAC_MODE_PWRDN
  } qdac_mode_t;

  typedef struct packed {
    logic [1:0]        chan;
    qdac_mode_t        mode;
    logic [CODE_W-1:0] code;
    logic [1:0]        pad;
  } qdac_word_t;

endpackage

// [tb/qdac_checker.sv]
`timescale 1ns/1ps
module qdac_checker #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic                   clk_sys_i,
  input wire logic                   rst_b_i,
  input wire logic                   s_axi_awvalid_i,
  input wire logic                   s_axi_awready_o,
  input wire logic                   s_axi_wvalid_i,
  input wire logic                   s_axi_wready_o,
  input wire logic [1:0]             s_axi_bresp_o,
  input wire logic                   s_axi_bvalid_o,
  input wire logic                   s_axi_bready_i,
  input wire logic                   s_axi_arvalid_i,
  input wire logic                   s_axi_arready_o,
  input wire logic [31:0]            s_axi_rdata_o,
  input wire logic [1:0]             s_axi_rresp_o,
  input wire logic                   s_axi_rvalid_o,
  input wire logic                   s_axi_rready_i,
  input wire logic                   frame_sel_b_i,
  input wire logic [qdac_pkg::CODE_W-1:0] channel_a_output_o,
  input wire logic [qdac_pkg::CODE_W-1:0] channel_b_output_o,
  input wire logic [qdac_pkg::CODE_W-1:0] channel_c_output_o,
  input wire logic [qdac_pkg::CODE_W-1:0] channel_d_output_o,
  input wire logic                   power_down_o
);
  logic [3:0] idle_cnt;
  logic [3:0] next_idle_cnt;
  logic       seen;
  logic       next_seen;
  wire  [39:0] outs = {channel_d_output_o, channel_c_output_o, channel_b_output_o, channel_a_output_o};

  // ----------------------------------------
  // helper state
  // ----------------------------------------
  // idle count saturates so a long pause never wraps back to zero
  always_comb
  begin
    next_idle_cnt = !frame_sel_b_i ? 4'h0 : (idle_cnt == 4'hf) ? idle_cnt : idle_cnt + 4'h1;
    next_seen     = seen | !frame_sel_b_i;
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      idle_cnt <= 4'h0;
      seen     <= 1'b0;
    end
    else
    begin
      idle_cnt <= next_idle_cnt;
      seen     <= next_seen;
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write answer dropped early");
  rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read answer dropped early");
  arready_excl_a: assert property (s_axi_arready_o == !s_axi_rvalid_o)
    else $error("read address ready wrong");
  wr_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    && !s_axi_bvalid_o |=> ##1 s_axi_bvalid_o) else $error("write answer late");
  rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  rd_err_zero_a: assert property (s_axi_rvalid_o && s_axi_rresp_o == qdac_pkg::RESP_SLVERR |-> s_axi_rdata_o == 0)
    else $error("refused read carries data");
  pd_zero_a: assert property (power_down_o |-> outs == 40'h0)
    else $error("output live while powered down");
  idle_hold_a: assert property (idle_cnt > 4'h7 |-> $stable(outs) && $stable(power_down_o))
    else $error("output moved with no frame");
  reset_zero_a: assert property (!seen |-> outs == 40'h0 && !power_down_o)
    else $error("output not zero before first frame");
endmodule

bind qdac_top qdac_checker #(.ADDR_W(ADDR_W)) i_qdac_checker (
  .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i), .frame_sel_b_i(frame_sel_b_i),
  .channel_a_output_o(channel_a_output_o), .channel_b_output_o(channel_b_output_o),
  .channel_c_output_o(channel_c_output_o), .channel_d_output_o(channel_d_output_o), .power_down_o(power_down_o));

// [tb/qdac_host.sv]
`timescale 1ns/1ps
module qdac_host (
  input  wire logic        go_i,
  input  wire logic [15:0] word_i,
  input  wire logic [4:0]  nbits_i,
  output logic             busy_o,
  output logic             sclk_o,
  output logic             frame_sel_b_o,
  output logic             sdata_o
);
  initial
  begin
    busy_o        = 1'b0;
    sclk_o        = 1'b1;
    frame_sel_b_o = 1'b1;
    sdata_o       = 1'b0;
  end

  // one frame per go pulse; clock parked high between frames
  always @(posedge go_i)
  begin
    busy_o = 1'b1;
    #3.7 frame_sel_b_o = 1'b0;
    for (int i = 0; i < nbits_i; i++)
    begin
      sdata_o = (i < 16) ? word_i[15 - i] : 1'($urandom);
      #15 sclk_o = 1'b0;
      #15 sclk_o = 1'b1;
    end
    #15 frame_sel_b_o = 1'b1;
    sdata_o = !sdata_o; // released line must not look valid
    #400 busy_o = 1'b0; // gap keeps the next frame clear of the crossing
  end
endmodule

// [tb/tb_quad_dac_serial_control.sv]
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; \
  $display("mismatch at %0t: got %h exp %h", $time, got, exp); end end
module tb_quad_dac_serial_control;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        go = 1'b0, snap = 1'b0, m_pd = 1'b0, m_en = 1'b1;
  logic [1:0]  m_term = 2'h0;
  logic [15:0] word = 16'h0;
  logic [4:0]  nbits = 5'h10;
  logic [9:0]  inr [4] = '{default: 10'h0};
  logic [9:0]  outv [4] = '{default: 10'h0};
  logic [47:0] exp_q [$];
  wire         awready, wready, arready, bvalid, rvalid, busy, sclk, fsel_b, sdata, pd;
  wire  [1:0]  bresp, rresp, term;
  wire  [31:0] rdata;
  wire  [9:0]  ch_a, ch_b, ch_c, ch_d;
  int          error_cnt = 0, n_tests = 0, cyc = 0, m_cnt = 0;

  qdac_top i_qdac_top (
    .clk_sys_i(clk), .rst_b_i(rst_b), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .sclk_i(sclk),
    .frame_sel_b_i(fsel_b), .sdata_i(sdata), .channel_a_output_o(ch_a), .channel_b_output_o(ch_b),
    .channel_c_output_o(ch_c), .channel_d_output_o(ch_d), .power_down_o(pd), .termination_o(term));
  qdac_host i_qdac_host (.go_i(go), .word_i(word), .nbits_i(nbits), .busy_o(busy), .sclk_o(sclk),
    .frame_sel_b_o(fsel_b), .sdata_o(sdata));

  // ----------------------------------------
  // clock, timeout, result watcher
  // ----------------------------------------
  always #50 clk = ~clk;

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      final_report();
    end
  end

  // results are taken off the queue in the order they were noted
  always @(posedge clk)
  begin
    if (rvalid && rready) chk({2'd0, 14'h0, rresp, rdata});
    if (bvalid && bready) chk({2'd1, 14'h0, bresp, 32'h0});
    if (snap) chk({2'd2, 3'h0, pd, pd ? term : 2'b00, ch_d, ch_c, ch_b, ch_a});
  end

  task automatic chk(input logic [47:0] obs);
    logic [47:0] e;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : 48'hx;
    `CHK(obs, e)
  endtask

  // ----------------------------------------
  // drivers and model
  // ----------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({2'd1, 14'h0, r, 32'h0});
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin @(posedge clk); if (awready) awvalid <= 1'b0; if (wready) wvalid <= 1'b0; end while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d);
    exp_q.push_back({2'd0, 14'h0, r, d});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin @(posedge clk); if (arready) arvalid <= 1'b0; end while (!rvalid);
    rready <= 1'b0;
  endtask

  task automatic check_out();
    exp_q.push_back({2'd2, 3'h0, m_pd, m_pd ? m_term : 2'b00, m_pd ? 40'h0 : {outv[3], outv[2], outv[1], outv[0]}});
    @(posedge clk) snap <= 1'b1;
    @(posedge clk) snap <= 1'b0;
  endtask

  // model update only for complete frames while the link is enabled
  task automatic frame(input logic [15:0] w, input logic [4:0] n);
    qdac_pkg::qdac_word_t f;
    f = w;
    if (n >= 5'd16 && m_en)
    begin
      m_cnt++;
      inr[f.chan] = (f.mode == qdac_pkg::QDAC_MODE_PWRDN) ? inr[f.chan] : f.code;
      if (f.mode == qdac_pkg::QDAC_MODE_UPD_ONE) outv[f.chan] = f.code;
      if (f.mode == qdac_pkg::QDAC_MODE_UPD_ALL) outv = inr;
      if (f.mode == qdac_pkg::QDAC_MODE_PWRDN) m_term = f.chan;
      // power-down parks every output at zero; a later single update clears power-down for all but sets only its own channel
      if (f.mode == qdac_pkg::QDAC_MODE_PWRDN) outv = '{default: 10'h0};
      m_pd = (f.mode == qdac_pkg::QDAC_MODE_PWRDN) | (m_pd & (f.mode == qdac_pkg::QDAC_MODE_LOAD));
    end
    @(posedge clk);
    word <= w;
    nbits <= n;
    go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    while (busy) @(posedge clk);
    repeat (8) @(posedge clk);
    check_out();
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    logic [15:0] w;
    void'($urandom(32'h241849bc));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    check_out();
    axi_rd(qdac_pkg::OFS_CTRL, qdac_pkg::RESP_OKAY, 32'h1);
    axi_rd(qdac_pkg::OFS_STATUS, qdac_pkg::RESP_OKAY, 32'h0);
    axi_rd(qdac_pkg::OFS_CODE_CD, qdac_pkg::RESP_OKAY, 32'h0);
    axi_rd(8'h10, qdac_pkg::RESP_SLVERR, 32'h0);
    axi_wr(qdac_pkg::OFS_STATUS, 32'hffffffff, qdac_pkg::RESP_OKAY);
    axi_wr(8'h20, 32'h1, qdac_pkg::RESP_SLVERR);
    axi_rd(qdac_pkg::OFS_STATUS, qdac_pkg::RESP_OKAY, 32'h0);
    frame(16'h7ffc, 5'd10);
    for (int m = 0; m < 4; m++)
      for (int c = 0; c < 4; c++)
        frame({c[1:0], m[1:0], 10'($urandom), 2'b00}, 5'd16);
    for (int k = 0; k < 12; k++)
    begin
      w = 16'($urandom);
      frame(w, (k % 3 == 0) ? 5'd15 : 5'(16 + $urandom % 4));
    end
    axi_wr(qdac_pkg::OFS_CTRL, 32'h0, qdac_pkg::RESP_OKAY);
    axi_rd(qdac_pkg::OFS_CTRL, qdac_pkg::RESP_OKAY, 32'h0);
    m_en = 1'b0;
    frame(16'h63fc, 5'd16);
    m_en = 1'b1;
    axi_wr(qdac_pkg::OFS_CTRL, 32'h1, qdac_pkg::RESP_OKAY);
    frame(16'h6abc, 5'd16);
    axi_rd(qdac_pkg::OFS_STATUS, qdac_pkg::RESP_OKAY, {16'(m_cnt), 12'h0, 1'(m_cnt != 0), m_term, m_pd});
    axi_rd(qdac_pkg::OFS_CODE_AB, qdac_pkg::RESP_OKAY, {6'h0, outv[1], 6'h0, outv[0]});
    // let the watcher take the last result before the run ends
    repeat (2) @(posedge clk);
    final_report();
  end

  task automatic final_report();
    // a result that never showed up is a mismatch too
    if (exp_q.size() != 0)
    begin
      error_cnt++;
      $display("mismatch at %0t: %0d results never seen", $time, exp_q.size());
    end
    if (error_cnt == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
endmodule
